// File: hdl/swcc_top.sv
/*
 * Sleep entry and wake-up clock control with an AXI4-Lite register slave.
 * Assumes sleep_req, halt_req and wdt_overflow are one-cycle aclk pulses from the core
 * and wake_irq an aclk-domain level; nmi_pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
`include "swcc_cfg.svh"
module swcc_top #(
    parameter int ECO_DELAY_CYCLES = `SWCC_ECO_DELAY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_req,
    input wire logic halt_req,
    input wire logic wake_irq,
    input wire logic nmi_pin,
    input wire logic wdt_overflow,
    output logic cpu_run,
    output logic low_power,
    output logic economy_mode,
    output logic [1:0] system_clock_select,
    output logic [1:0] system_clock_divider,
    output logic internal_osc_enable,
    output logic low_speed_osc_enable,
    output logic fast_osc_enable,
    output logic external_clock_enable,
    output logic [2:0] fast_osc_settle_wait,
    output logic sys_reset_req,
    output logic irq
);
    swcc_pkg::swcc_state_type state_reg;
    logic [1:0] wup_sel_reg;
    logic [1:0] wup_div_reg;
    logic reconfig_reg;
    swcc_pkg::swcc_src_mask_type osc_en_reg;
    swcc_pkg::swcc_src_mask_type keep_reg;
    logic [2:0] settle_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic [2:0] event_set;
    logic eco_ok_reg;
    logic nmi_sync;
    logic delay_done;
    logic wake_any;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic [31:0] sclk_word;
    logic [31:0] osc_word;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic rd_ok;

    function automatic logic [31:0] swcc_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        swcc_merge = res;
    endfunction : swcc_merge

    swcc_sync #(.W(1)) u_nmi_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .async_in(nmi_pin),
        .sync_out(nmi_sync)
    );

    // Delay restarts on every sleep entry and is dropped on leaving sleep
    swcc_delay #(.CYCLES(ECO_DELAY_CYCLES), .W(32)) u_eco_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(state_reg == swcc_pkg::SWCC_RUN && sleep_req),
        .clear(state_reg != swcc_pkg::SWCC_SLEEP && state_reg != swcc_pkg::SWCC_RUN),
        .done(delay_done)
    );

    assign wake_any = nmi_sync || wake_irq;
    assign cpu_run = state_reg == swcc_pkg::SWCC_RUN;
    assign economy_mode = state_reg == swcc_pkg::SWCC_ECON;
    assign low_power = state_reg == swcc_pkg::SWCC_HALT || state_reg == swcc_pkg::SWCC_SLEEP
                       || economy_mode;
    assign internal_osc_enable = osc_en_reg[0];
    assign low_speed_osc_enable = osc_en_reg[1];
    assign fast_osc_enable = osc_en_reg[2];
    assign external_clock_enable = osc_en_reg[3];
    assign fast_osc_settle_wait = settle_reg;
    assign irq = |(status_reg & mask_reg);

    // Power-mode sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= swcc_pkg::SWCC_RUN;
            eco_ok_reg <= 1'b0;
        end else if (ce) begin
            case (state_reg)
                swcc_pkg::SWCC_RUN: begin
                    if (sleep_req) begin
                        state_reg <= swcc_pkg::SWCC_SLEEP;
                        eco_ok_reg <= osc_en_reg == `SWCC_LOW_ONLY;
                    end else if (halt_req) begin
                        state_reg <= swcc_pkg::SWCC_HALT;
                    end
                end
                swcc_pkg::SWCC_HALT: begin
                    if (wake_any) begin
                        state_reg <= swcc_pkg::SWCC_RUN;
                    end
                end
                swcc_pkg::SWCC_SLEEP: begin
                    if (wake_any) begin
                        state_reg <= swcc_pkg::SWCC_WAKE;
                    end else if (delay_done && eco_ok_reg) begin
                        state_reg <= swcc_pkg::SWCC_ECON;
                    end
                end
                swcc_pkg::SWCC_ECON: begin
                    if (wake_any) begin
                        state_reg <= swcc_pkg::SWCC_WAKE;
                    end
                end
                // Clock selections load on the edge that leaves this state, the same edge that resumes fetch
                swcc_pkg::SWCC_WAKE: state_reg <= swcc_pkg::SWCC_RUN;
                default: state_reg <= swcc_pkg::SWCC_RUN;
            endcase
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg == `SWCC_OFF_MODE
                                || awaddr_reg > `SWCC_OFF_MODE) ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign sclk_word = {16'h0000, reconfig_reg, 1'b0, wup_div_reg, 2'h0, wup_sel_reg,
                        2'h0, system_clock_divider, 2'h0, system_clock_select};
    assign osc_word = {13'h0000, settle_reg, 4'h0, keep_reg, 4'h0, osc_en_reg};

    always_comb begin
        wr_word = 32'h0000_0000;
        if (awaddr_reg == `SWCC_OFF_SCLK) begin
            wr_word = swcc_merge(sclk_word, wdata_reg, wstrb_reg);
        end else if (awaddr_reg == `SWCC_OFF_OSC) begin
            wr_word = swcc_merge(osc_word, wdata_reg, wstrb_reg);
        end else if (awaddr_reg == `SWCC_OFF_STAT) begin
            wr_word = swcc_merge(32'h0000_0000, wdata_reg, wstrb_reg);
        end else begin
            wr_word = swcc_merge({29'h0, mask_reg}, wdata_reg, wstrb_reg);
        end
    end

    // System clock select and divider, reloaded at wake-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_clock_select <= `SWCC_SEL_RESET;
            system_clock_divider <= `SWCC_DIV_RESET;
            wup_sel_reg <= `SWCC_SEL_RESET;
            wup_div_reg <= `SWCC_DIV_RESET;
            reconfig_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == swcc_pkg::SWCC_WAKE && reconfig_reg) begin
                system_clock_select <= wup_sel_reg;
                system_clock_divider <= wup_div_reg;
            end else if (wr_fire && awaddr_reg == `SWCC_OFF_SCLK) begin
                system_clock_select <= wr_word[`SWCC_SEL_LSB +: 2];
                system_clock_divider <= wr_word[`SWCC_DIV_LSB +: 2];
            end
            if (wr_fire && awaddr_reg == `SWCC_OFF_SCLK) begin
                wup_sel_reg <= wr_word[`SWCC_WSEL_LSB +: 2];
                wup_div_reg <= wr_word[`SWCC_WDIV_LSB +: 2];
                reconfig_reg <= wr_word[`SWCC_RECONF_BIT];
            end
        end
    end

    // Oscillator enables; software must keep the wake-up source enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_en_reg <= `SWCC_EN_RESET;
            keep_reg <= 4'h0;
            settle_reg <= `SWCC_SETTLE_RESET;
        end else if (ce) begin
            if (state_reg == swcc_pkg::SWCC_WAKE && reconfig_reg) begin
                osc_en_reg <= osc_en_reg & (swcc_pkg::swcc_src_bit(wup_sel_reg) | keep_reg);
            end else if (wr_fire && awaddr_reg == `SWCC_OFF_OSC) begin
                osc_en_reg <= wr_word[`SWCC_EN_LSB +: 4];
            end
            if (wr_fire && awaddr_reg == `SWCC_OFF_OSC) begin
                keep_reg <= wr_word[`SWCC_KEEP_LSB +: 4];
                settle_reg <= wr_word[`SWCC_SETTLE_LSB +: 3];
            end
        end
    end

    // Sticky events: economy reached, wake-up done, watchdog overflow
    assign event_set = {wdt_overflow,
                        state_reg == swcc_pkg::SWCC_WAKE,
                        state_reg == swcc_pkg::SWCC_SLEEP && !wake_any && delay_done && eco_ok_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 3'h0;
            mask_reg <= 3'h0;
        end else if (ce) begin
            // A set in the clearing cycle wins, so no event is lost
            if (wr_fire && awaddr_reg == `SWCC_OFF_STAT) begin
                status_reg <= (status_reg & ~wr_word[2:0]) | event_set;
            end else begin
                status_reg <= status_reg | event_set;
            end
            if (wr_fire && awaddr_reg == `SWCC_OFF_MASK) begin
                mask_reg <= wr_word[2:0];
            end
        end
    end

    // Watchdog overflow is a reset whenever ce is high, never a maskable choice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_req <= 1'b0;
        end else if (ce) begin
            sys_reset_req <= wdt_overflow;
        end
    end

    // AXI4-Lite read path
    always_comb begin
        rd_ok = 1'b1;
        if (s_axi_araddr == `SWCC_OFF_SCLK) begin
            rd_word = sclk_word;
        end else if (s_axi_araddr == `SWCC_OFF_OSC) begin
            rd_word = osc_word;
        end else if (s_axi_araddr == `SWCC_OFF_STAT) begin
            rd_word = {29'h0, status_reg};
        end else if (s_axi_araddr == `SWCC_OFF_MASK) begin
            rd_word = {29'h0, mask_reg};
        end else if (s_axi_araddr == `SWCC_OFF_MODE) begin
            rd_word = {29'h0, state_reg == swcc_pkg::SWCC_HALT, low_power, economy_mode};
        end else begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_eco_after_delay: assert property (ce && state_reg == swcc_pkg::SWCC_SLEEP && eco_ok_reg
        && delay_done && !wake_any |=> economy_mode && status_reg[0]) else $error("no economy entry");
    a_no_eco_other: assert property (ce && cpu_run && sleep_req && osc_en_reg != `SWCC_LOW_ONLY
        |=> !economy_mode [*3]) else $error("economy with other source");
    a_wake_clears_en: assert property (ce && state_reg == swcc_pkg::SWCC_WAKE && reconfig_reg
        |=> (osc_en_reg & ~$past(keep_reg) & ~swcc_pkg::swcc_src_bit($past(wup_sel_reg))) == 4'h0)
        else $error("enable not cleared");
    a_keep_running: assert property (ce && state_reg == swcc_pkg::SWCC_WAKE
        |=> (osc_en_reg & $past(keep_reg)) == ($past(osc_en_reg) & $past(keep_reg)))
        else $error("kept source stopped");
    a_wake_src_load: assert property (ce && state_reg == swcc_pkg::SWCC_WAKE && !wr_fire
        |=> system_clock_select == ($past(reconfig_reg) ? $past(wup_sel_reg)
        : $past(system_clock_select))) else $error("wrong wake source");
    a_nmi_wakes: assert property (ce && low_power && nmi_sync |=> !low_power)
        else $error("nmi ignored");
    a_settle_reset: assert property ($rose(aresetn) |-> settle_reg == `SWCC_SETTLE_RESET)
        else $error("settle wait reset");
    a_wdt_reset_req: assert property (ce && wdt_overflow |=> sys_reset_req && status_reg[2])
        else $error("no reset request");
    a_resume_after_apply: assert property ($rose(cpu_run) |-> $past(state_reg) != swcc_pkg::SWCC_SLEEP
        && $past(state_reg) != swcc_pkg::SWCC_ECON) else $error("resume skipped wake");

    c_economy_entry: cover property (state_reg == swcc_pkg::SWCC_SLEEP ##1 economy_mode);
    c_wake_reconfig: cover property (state_reg == swcc_pkg::SWCC_WAKE && reconfig_reg ##1 cpu_run);
    c_nmi_from_halt: cover property (state_reg == swcc_pkg::SWCC_HALT && nmi_sync ##1 cpu_run);
endmodule : swcc_top

// File: hdl/swcc_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * sleep and wake clock control block.
 * Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
// Summary of operation
// - Normal-mode sleep with only low-speed oscillator: economy mode after 1 ms, flag set
// - Any other source running at sleep entry keeps the device out of economy mode
// - Reconfig set: wake-up clears enables of all sources but the system source and those marked keep-running
// - Sources marked keep-running-in-sleep keep their enable value unchanged after wake-up
// - Wake-up select loads system clock select; ignored while reconfig is 0
// - NMI ends halt or sleep, whatever its source
// - Fast-oscillator settling wait field resets to zero
// - Watchdog overflow raises a system reset request and sets status flag 2 whenever ce is high, an interrupt when unmasked
`ifndef SWCC_CFG_SVH
`define SWCC_CFG_SVH
`define SWCC_OFF_SCLK 8'h00
`define SWCC_OFF_OSC 8'h04
`define SWCC_OFF_STAT 8'h08
`define SWCC_OFF_MASK 8'h0c
`define SWCC_OFF_MODE 8'h10
`define SWCC_SEL_LSB 0
`define SWCC_DIV_LSB 4
`define SWCC_WSEL_LSB 8
`define SWCC_WDIV_LSB 12
`define SWCC_RECONF_BIT 15
`define SWCC_EN_LSB 0
`define SWCC_KEEP_LSB 8
`define SWCC_SETTLE_LSB 16
`define SWCC_SEL_RESET 2'h0
`define SWCC_DIV_RESET 2'h0
`define SWCC_EN_RESET 4'h1
`define SWCC_SETTLE_RESET 3'h0
`define SWCC_LOW_ONLY 4'h2
`define SWCC_ECO_DELAY_NS 1000000
`define SWCC_CLK_PERIOD_NS 8
`define SWCC_ECO_DELAY_CYC ((`SWCC_ECO_DELAY_NS + `SWCC_CLK_PERIOD_NS - 1) / `SWCC_CLK_PERIOD_NS)
`endif

// File: hdl/swcc_pkg.sv
/*
 * Types shared by the sleep and wake clock control files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package swcc_pkg;
    typedef enum logic [2:0] {SWCC_RUN, SWCC_HALT, SWCC_SLEEP, SWCC_ECON, SWCC_WAKE} swcc_state_type;
    typedef logic [3:0] swcc_src_mask_type;

    // Select codes 0..3 map onto enable bits 0..3
    function automatic swcc_src_mask_type swcc_src_bit(input logic [1:0] sel);
        swcc_src_bit = 4'h1 << sel;
    endfunction : swcc_src_bit
endpackage : swcc_pkg

// File: hdl/swcc_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to aclk.
 */
`timescale 1ns/1ns
module swcc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // A change counts only once the last two stages agree
            if (s2_reg == s3_reg) begin
                sync_out <= s3_reg;
            end
        end
    end
endmodule : swcc_sync

// File: hdl/swcc_delay.sv
/*
 * One-shot delay counter: done rises CYCLES enabled clocks after start.
 * Assumes start and clear come from aclk-domain logic.
 */
`timescale 1ns/1ns
module swcc_delay #(
    parameter int CYCLES = 125000,
    parameter int W = 17
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic clear,
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic run_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                run_reg <= 1'b0;
                done <= 1'b0;
            end else if (start) begin
                cnt_reg <= W'(CYCLES - 1);
                run_reg <= 1'b1;
                done <= 1'b0;
            end else if (run_reg) begin
                if (cnt_reg == '0) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule : swcc_delay

// File: test/swcc_core_model.sv
/*
 * Core-side model: pulses sleep, halt and watchdog events, holds wake sources.
 * Assumes a swcc_top on the same aclk; requests change just after a rising edge.
 */
`timescale 1ns/1ns
module swcc_core_model (
    input wire logic aclk,
    input wire logic cpu_run,
    output logic sleep_req,
    output logic halt_req,
    output logic wake_irq,
    output logic nmi_pin,
    output logic wdt_overflow
);
    initial begin
        sleep_req = 1'b0;
        halt_req = 1'b0;
        wake_irq = 1'b0;
        nmi_pin = 1'b0;
        wdt_overflow = 1'b0;
    end

    // Kind 0 sleep, 1 halt, 2 watchdog overflow; one cycle wide
    task automatic pulse(input int kind);
        @(posedge aclk);
        sleep_req <= (kind == 0);
        halt_req <= (kind == 1);
        wdt_overflow <= (kind == 2);
        @(posedge aclk);
        sleep_req <= 1'b0;
        halt_req <= 1'b0;
        wdt_overflow <= 1'b0;
    endtask : pulse

    // Held until the core runs again, so a slow synchroniser never loses it
    task automatic wake(input logic use_nmi);
        int n;
        n = 0;
        @(posedge aclk);
        wake_irq <= !use_nmi;
        nmi_pin <= use_nmi;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (!cpu_run && n < 50);
        @(posedge aclk);
        wake_irq <= 1'b0;
        nmi_pin <= 1'b0;
    endtask : wake
endmodule : swcc_core_model

// File: test/tb_sleep_wake_clock_control.sv
/*
 * Self-checking bench for the sleep and wake clock control block.
 * Assumes swcc_core_model drives the core pins; AXI4-Lite is driven here.
 */
`timescale 1ns/1ns
`include "swcc_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_sleep_wake_clock_control;
    logic aclk, aresetn, ce;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, system_clock_select, system_clock_divider;
    logic sleep_req, halt_req, wake_irq, nmi_pin, wdt_overflow;
    logic cpu_run, low_power, economy_mode, sys_reset_req, irq;
    logic internal_osc_enable, low_speed_osc_enable, fast_osc_enable, external_clock_enable;
    logic [2:0] fast_osc_settle_wait;
    int error_cnt, checks_done;
    logic [1:0] last_bresp;

    // Short economy delay keeps the run brief; expectations follow from it
    swcc_top #(.ECO_DELAY_CYCLES(20)) dut (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_req,
        .halt_req, .wake_irq, .nmi_pin, .wdt_overflow, .cpu_run, .low_power,
        .economy_mode, .system_clock_select, .system_clock_divider,
        .internal_osc_enable, .low_speed_osc_enable, .fast_osc_enable,
        .external_clock_enable, .fast_osc_settle_wait, .sys_reset_req, .irq
    );

    swcc_core_model core (
        .aclk, .cpu_run, .sleep_req, .halt_req, .wake_irq, .nmi_pin, .wdt_overflow
    );

    always #4 aclk = ~aclk;

    function automatic logic [3:0] osc_ens();
        return {external_clock_enable, fast_osc_enable, low_speed_osc_enable,
            internal_osc_enable};
    endfunction : osc_ens

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bready && s_axi_bvalid;
            last_bresp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end while (!tb && n < 50);
        s_axi_bready <= 1'b0;
        if (!tb) error_cnt++;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rready && s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end while (!tr && n < 50);
        s_axi_rready <= 1'b0;
        if (!tr) error_cnt++;
    endtask : axi_rd

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`SWCC_OFF_OSC, d, r);
        `CHK("settle field", 3'h0, d[18:16])
        `CHK("settle port", 3'h0, fast_osc_settle_wait)
        `CHK("reset enables", 4'h1, osc_ens())
        `CHK("osc rresp", 2'h0, r)
        axi_rd(8'h14, d, r);
        `CHK("unmapped rresp", 2'h2, r)
        axi_wr(`SWCC_OFF_MODE, 32'h0000_0007);
        `CHK("mode bresp", 2'h2, last_bresp)
        // Only the settle byte lane is written; enables must stay as they are
        s_axi_wstrb <= 4'h4;
        axi_wr(`SWCC_OFF_OSC, 32'h0005_00ff);
        s_axi_wstrb <= 4'hf;
        `CHK("lane settle", 3'h5, fast_osc_settle_wait)
        `CHK("lane enables", 4'h1, osc_ens())
        $display("test reset done");
    endtask : t_reset

    task automatic t_economy;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        axi_wr(`SWCC_OFF_OSC, 32'h0000_0002);
        axi_wr(`SWCC_OFF_MASK, 32'h0000_0001);
        core.pulse(0);
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (!economy_mode && n < 100);
        // Economy follows one cycle after the delay counter runs out
        `CHK("economy delay", 21, n)
        `CHK("done irq", 1'b1, irq)
        axi_rd(`SWCC_OFF_STAT, d, r);
        `CHK("done flag", 1'b1, d[0])
        core.wake(1'b0);
        `CHK("run after eco", 1'b1, cpu_run)
        `CHK("eco left", 1'b0, economy_mode)
        axi_wr(`SWCC_OFF_STAT, 32'h0000_0007);
        `CHK("irq cleared", 1'b0, irq)
        $display("test economy done");
    endtask : t_economy

    task automatic t_no_economy;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`SWCC_OFF_OSC, 32'h0000_0003);
        core.pulse(0);
        repeat (40) @(posedge aclk);
        #1;
        `CHK("no economy", 1'b0, economy_mode)
        `CHK("still asleep", 1'b1, low_power)
        core.wake(1'b0);
        axi_rd(`SWCC_OFF_STAT, d, r);
        `CHK("no done flag", 1'b0, d[0])
        axi_wr(`SWCC_OFF_STAT, 32'h0000_0007);
        $display("test no economy done");
    endtask : t_no_economy

    task automatic t_reconfig;
        // Wake source is enabled and differs from the current one
        axi_wr(`SWCC_OFF_OSC, 32'h0000_080f);
        axi_wr(`SWCC_OFF_SCLK, 32'h0000_9200);
        core.pulse(0);
        core.wake(1'b1);
        `CHK("nmi wake", 1'b1, cpu_run)
        `CHK("wake select", 2'h2, system_clock_select)
        `CHK("wake divider", 2'h1, system_clock_divider)
        `CHK("wake enables", 4'hc, osc_ens())
        axi_wr(`SWCC_OFF_SCLK, 32'h0000_1302);
        axi_wr(`SWCC_OFF_OSC, 32'h0000_000f);
        core.pulse(0);
        core.wake(1'b0);
        `CHK("select kept", 2'h2, system_clock_select)
        `CHK("divider kept", 2'h0, system_clock_divider)
        `CHK("enables kept", 4'hf, osc_ens())
        $display("test reconfig done");
    endtask : t_reconfig

    task automatic t_halt_nmi;
        logic [31:0] d;
        logic [1:0] r;
        core.pulse(1);
        @(posedge aclk);
        #1;
        `CHK("halted", 1'b0, cpu_run)
        axi_rd(`SWCC_OFF_MODE, d, r);
        `CHK("mode halt", 3'h6, d[2:0])
        core.wake(1'b1);
        `CHK("nmi ends halt", 1'b1, cpu_run)
        `CHK("halt exit", 1'b0, low_power)
        $display("test halt nmi done");
    endtask : t_halt_nmi

    task automatic t_watchdog;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`SWCC_OFF_MASK, 32'h0000_0000);
        core.pulse(2);
        #1;
        `CHK("reset request", 1'b1, sys_reset_req)
        `CHK("masked irq", 1'b0, irq)
        @(posedge aclk);
        #1;
        `CHK("request one cycle", 1'b0, sys_reset_req)
        axi_rd(`SWCC_OFF_STAT, d, r);
        `CHK("wdt flag", 1'b1, d[2])
        axi_wr(`SWCC_OFF_MASK, 32'h0000_0004);
        `CHK("unmasked irq", 1'b1, irq)
        axi_wr(`SWCC_OFF_STAT, 32'h0000_0004);
        `CHK("w1c irq", 1'b0, irq)
        $display("test watchdog done");
    endtask : t_watchdog

    task automatic t_freeze;
        @(posedge aclk);
        ce <= 1'b0;
        core.pulse(2);
        #1;
        `CHK("frozen wdt", 1'b0, sys_reset_req)
        @(posedge aclk);
        ce <= 1'b1;
        core.pulse(2);
        #1;
        `CHK("thawed wdt", 1'b1, sys_reset_req)
        $display("test freeze done");
    endtask : t_freeze

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_economy();
        t_no_economy();
        t_reconfig();
        t_halt_nmi();
        t_watchdog();
        t_freeze();
        summarize();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        summarize();
    end
endmodule : tb_sleep_wake_clock_control
